// File: rtl/sgc_pkg.sv
// sgc_pkg: constants, field positions and carriers for the switch global
// control register bank.
// assumes one 100 MHz switch clock shared by bus, filters and aging logic.
package sgc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] SGC_IDX_CTRL_A = 6'h02;
    localparam logic [5:0] SGC_IDX_CTRL_B = 6'h03;
    localparam logic [5:0] SGC_IDX_VLAN = 6'h04;
    // control a fields
    localparam int SGC_A_CONF_BACKOFF = 7;
    localparam int SGC_A_SOFT_RESET = 6;
    localparam int SGC_A_FLUSH_DYN = 5;
    localparam int SGC_A_FLUSH_STAT = 4;
    localparam int SGC_A_STRICT_CTRL = 1;
    localparam int SGC_A_LINK_AGE = 0;
    localparam logic [7:0] SGC_A_RW_MASK = 8'hf3;
    localparam logic [7:0] SGC_A_RO_ONES = 8'h0c;
    localparam logic [7:0] SGC_A_RESET = 8'h00;
    // control b fields
    localparam int SGC_B_JUMBO = 6;
    localparam int SGC_B_TX_FC_DIS = 5;
    localparam int SGC_B_RX_FC_DIS = 4;
    localparam int SGC_B_LEN_CHECK = 3;
    localparam int SGC_B_AGING = 2;
    localparam int SGC_B_FAST_AGE = 1;
    localparam int SGC_B_AGGR_BACKOFF = 0;
    localparam logic [7:0] SGC_B_RW_MASK = 8'h7f;
    localparam logic [7:0] SGC_B_RESET = 8'h04;
    // vlan and storm fields
    localparam int SGC_V_VLAN_CROSS = 7;
    localparam int SGC_V_STORM_BCAST = 6;
    localparam logic [7:0] SGC_V_RW_MASK = 8'hc0;
    localparam logic [7:0] SGC_V_RESET = 8'hc0;
    // frame classification constants
    localparam logic [15:0] SGC_PAUSE_TYPE = 16'h8808;
    localparam logic [47:0] SGC_PAUSE_DA = 48'h0180c2000001;
    localparam logic [47:0] SGC_BCAST_DA = 48'hffffffffffff;
    localparam logic [15:0] SGC_LEN_LIMIT = 16'h05dc;
    // timing
    localparam longint SGC_CLK_MHZ = 100;
    localparam longint SGC_FAST_AGE_US = 800;
    localparam longint SGC_NORMAL_AGE_S = 300;
    localparam longint SGC_FAST_AGE_CYC = SGC_FAST_AGE_US * SGC_CLK_MHZ;
    localparam longint SGC_NORMAL_AGE_CYC =
        SGC_NORMAL_AGE_S * SGC_CLK_MHZ * 64'd1000000;
    localparam int SGC_AGE_W = 36;
    localparam int SGC_NPORT = 5;
    localparam int SGC_PORT_W = 3;

    // header summary of one received frame
    typedef struct packed {
        logic [15:0] type_len;
        logic [47:0] dest;
        logic [15:0] payload_len;
        logic is_flow_ctrl;
        logic known_ucast;
        logic is_mcast;
        logic crosses_vlan;
        logic single_dest;
        logic mirrored_away;
    } sgc_frame_t;

    // one mac table entry offered for flush qualification
    typedef struct packed {
        logic is_static;
        logic unicast;
        logic [SGC_NPORT-1:0] fwd_ports;
        logic [SGC_PORT_W-1:0] port;
    } sgc_entry_t;

    typedef enum logic [1:0] {
        SGC_FL_IDLE,
        SGC_FL_DYN,
        SGC_FL_STAT
    } sgc_flush_t;
endpackage : sgc_pkg

// File: rtl/sgc_switch_global_control_regs.sv
// sgc_switch_global_control_regs: global control byte registers on a
// wishbone classic slave, with the frame filters, flush sequencing and
// aging timer they steer.
// assumes table, mac and phy logic share clk_in; link and strap pins async.
//
// Contract
// (RQ1) control a bit 7 selects the conformance test back-off; resets zero.
// (RQ2) soft reset clears state machines and data path, keeps configuration.
// (RQ3) writing one starts dynamic table flush; bit self clears afterwards.
// (RQ4) dynamic flush removes only entries of learning disabled ports.
// (RQ5) static flush removes unicast single port entries of non-learning ports.
// (RQ6) strict mode drops pause type or pause address; else flow control.
// (RQ7) link loss with link age on gives one fast aging cycle.
// (RQ8) any port losing link ages out all learned addresses.
// (RQ9) control b bit 6 enables 2 kb jumbo frames; resets zero.
// (RQ10) bit 5 clear follows negotiation for transmit pause; set forces off.
// (RQ11) bit 4 clear follows negotiation for receive pause; set forces off.
// (RQ12) both flow control disable bits reset from one strap pin.
// (RQ13) length check drops frames with length below 1500 that mismatch.
// (RQ14) control b bit 2 enables aging; resets one.
// (RQ15) fast aging bit shortens aging period to 800 us.
// (RQ16) aggressive back-off bit selects faster half duplex back-off.
// (RQ17) vlan cross bit set lets all frames cross; clear only unicast.
// (RQ18) mirrored single destination frames under port vlan are dropped.
// (RQ19) storm exclusion bit counts only broadcast frames; resets one.
// (RQ20) flush bits read one while busy; reserved bit writes ignored.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module sgc_switch_global_control_regs #(
    parameter longint FAST_AGE_CYC = sgc_pkg::SGC_FAST_AGE_CYC,
    parameter longint NORMAL_AGE_CYC = sgc_pkg::SGC_NORMAL_AGE_CYC
) (
    input wire logic clk_in, // switch clock
    input wire logic reset_in, // synchronous, active high
    input wire logic wb_cyc_in, // wishbone cycle
    input wire logic wb_stb_in, // wishbone strobe
    input wire logic wb_we_in, // write enable
    input wire logic [7:0] wb_adr_in, // byte address
    input wire logic [3:0] wb_sel_in, // byte lanes
    input wire logic [31:0] wb_dat_in, // write data
    output logic [31:0] wb_dat_out, // read data
    output logic wb_ack_out, // acknowledge
    input wire logic strap_fc_dis_in, // async strap for flow control
    input wire logic [sgc_pkg::SGC_NPORT-1:0] link_up_in, // async links
    input wire logic an_tx_pause_in, // negotiated transmit pause
    input wire logic an_rx_pause_in, // negotiated receive pause
    input wire logic frame_valid_in, // frame header present
    input wire sgc_pkg::sgc_frame_t frame_in, // frame header
    input wire logic entry_valid_in, // table entry offered
    input wire sgc_pkg::sgc_entry_t entry_in, // table entry
    input wire logic [sgc_pkg::SGC_NPORT-1:0] learn_dis_in, // per port
    input wire logic flush_done_in, // table logic finished flush
    output logic core_reset_out, // fsm and data path reset
    output logic rx_enable_out, // reception allowed
    output logic conf_backoff_out, // conformance back-off
    output logic aggr_backoff_out, // aggressive back-off
    output logic jumbo_en_out, // 2 kb frames accepted
    output logic tx_fc_en_out, // transmit pause active
    output logic rx_fc_en_out, // receive pause active
    output logic flush_dyn_start_out, // one cycle pulse
    output logic flush_stat_start_out, // one cycle pulse
    output logic entry_remove_out, // offered entry to be removed
    output logic drop_valid_out, // drop verdict valid
    output logic drop_out, // frame discard
    output logic storm_count_out, // frame counts for storm
    output logic age_tick_out, // one aging cycle ends
    output logic age_all_out // age out all learned addresses
);
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] vlan_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [1:0] strap_sync_r;
    logic [sgc_pkg::SGC_NPORT-1:0] link_s1_r;
    logic [sgc_pkg::SGC_NPORT-1:0] link_s2_r;
    logic [sgc_pkg::SGC_NPORT-1:0] link_prev_r;
    sgc_pkg::sgc_flush_t flush_r;
    logic [sgc_pkg::SGC_AGE_W-1:0] age_cnt_r;
    logic fast_once_r;
    logic wr_req;
    logic [5:0] idx;
    logic link_loss;
    logic soft_rst;
    logic age_end;
    logic [sgc_pkg::SGC_AGE_W-1:0] age_period;
    logic [7:0] wbyte;

    assign idx = wb_adr_in[7:2];
    assign wbyte = wb_dat_in[7:0];
    assign wr_req = wb_cyc_in & wb_stb_in & wb_we_in & ~ack_r & wb_sel_in[0];
    assign soft_rst = ctrl_a_r[sgc_pkg::SGC_A_SOFT_RESET];
    assign link_loss = |(link_prev_r & ~link_s2_r);

    // wishbone answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_in & wb_stb_in & ~ack_r;
        end
    end

    // read mux; unmapped indices answer zero rather than stall the bus
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdat_r <= 32'h0000_0000;
        end else if (wb_cyc_in & wb_stb_in & ~ack_r) begin
            if (idx == sgc_pkg::SGC_IDX_CTRL_A) begin
                rdat_r <= {24'h000000, ctrl_a_r | sgc_pkg::SGC_A_RO_ONES};
            end else if (idx == sgc_pkg::SGC_IDX_CTRL_B) begin
                rdat_r <= {24'h000000, ctrl_b_r};
            end else if (idx == sgc_pkg::SGC_IDX_VLAN) begin
                rdat_r <= {24'h000000, vlan_r};
            end else begin
                rdat_r <= 32'h0000_0000;
            end
        end
    end

    // strap passes two flops; free running so it is settled at release
    always_ff @(posedge clk_in) begin
        strap_sync_r <= {strap_sync_r[0], strap_fc_dis_in};
    end

    // control a; flush bits stay one until the table logic is done
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_a_r <= sgc_pkg::SGC_A_RESET;
        end else begin
            if (wr_req && idx == sgc_pkg::SGC_IDX_CTRL_A) begin
                ctrl_a_r <= wbyte & sgc_pkg::SGC_A_RW_MASK; // RQ20
                // a flush already running cannot be cancelled by a zero
                if (flush_r != sgc_pkg::SGC_FL_IDLE && !flush_done_in) begin
                    ctrl_a_r[sgc_pkg::SGC_A_FLUSH_DYN] <=
                        wbyte[sgc_pkg::SGC_A_FLUSH_DYN] |
                        ctrl_a_r[sgc_pkg::SGC_A_FLUSH_DYN];
                    ctrl_a_r[sgc_pkg::SGC_A_FLUSH_STAT] <=
                        wbyte[sgc_pkg::SGC_A_FLUSH_STAT] |
                        ctrl_a_r[sgc_pkg::SGC_A_FLUSH_STAT];
                end
            end else if (flush_done_in || soft_rst) begin
                // self clearing once complete or when the fsm is reset
                if (flush_r == sgc_pkg::SGC_FL_DYN || soft_rst) begin
                    ctrl_a_r[sgc_pkg::SGC_A_FLUSH_DYN] <= 1'b0; // RQ3
                end
                if (flush_r == sgc_pkg::SGC_FL_STAT || soft_rst) begin
                    ctrl_a_r[sgc_pkg::SGC_A_FLUSH_STAT] <= 1'b0; // RQ20
                end
            end
        end
    end

    // control b; flow control disables take the strap at reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_b_r <= sgc_pkg::SGC_B_RESET; // RQ14
            ctrl_b_r[sgc_pkg::SGC_B_TX_FC_DIS] <= strap_sync_r[1]; // RQ12
            ctrl_b_r[sgc_pkg::SGC_B_RX_FC_DIS] <= strap_sync_r[1]; // RQ12
        end else if (wr_req && idx == sgc_pkg::SGC_IDX_CTRL_B) begin
            ctrl_b_r <= wbyte & sgc_pkg::SGC_B_RW_MASK;
        end
    end

    // vlan and storm register; only its two upper bits exist here
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            vlan_r <= sgc_pkg::SGC_V_RESET; // RQ17 RQ19
        end else if (wr_req && idx == sgc_pkg::SGC_IDX_VLAN) begin
            vlan_r <= wbyte & sgc_pkg::SGC_V_RW_MASK;
        end
    end

    // flush sequencer; dynamic wins when both bits are written together
    always_ff @(posedge clk_in) begin
        if (reset_in || soft_rst) begin
            flush_r <= sgc_pkg::SGC_FL_IDLE; // RQ2
            flush_dyn_start_out <= 1'b0;
            flush_stat_start_out <= 1'b0;
        end else begin
            flush_dyn_start_out <= 1'b0;
            flush_stat_start_out <= 1'b0;
            case (flush_r)
                sgc_pkg::SGC_FL_IDLE: begin
                    if (ctrl_a_r[sgc_pkg::SGC_A_FLUSH_DYN]) begin
                        flush_r <= sgc_pkg::SGC_FL_DYN;
                        flush_dyn_start_out <= 1'b1; // RQ3
                    end else if (ctrl_a_r[sgc_pkg::SGC_A_FLUSH_STAT]) begin
                        flush_r <= sgc_pkg::SGC_FL_STAT;
                        flush_stat_start_out <= 1'b1; // RQ5
                    end
                end
                sgc_pkg::SGC_FL_DYN, sgc_pkg::SGC_FL_STAT: begin
                    if (flush_done_in) begin
                        flush_r <= sgc_pkg::SGC_FL_IDLE;
                    end
                end
                default: begin
                    flush_r <= sgc_pkg::SGC_FL_IDLE;
                end
            endcase
        end
    end

    // entry qualification for the flush in progress
    always_ff @(posedge clk_in) begin
        if (reset_in || soft_rst) begin
            entry_remove_out <= 1'b0;
        end else if (!entry_valid_in) begin
            entry_remove_out <= 1'b0;
        end else if (flush_r == sgc_pkg::SGC_FL_DYN) begin
            entry_remove_out <= !entry_in.is_static &&
                learn_dis_in[entry_in.port]; // RQ4
        end else if (flush_r == sgc_pkg::SGC_FL_STAT) begin
            entry_remove_out <= entry_in.is_static && entry_in.unicast &&
                $onehot(entry_in.fwd_ports) &&
                |(entry_in.fwd_ports & learn_dis_in); // RQ5
        end else begin
            entry_remove_out <= 1'b0;
        end
    end

    // frame verdicts one cycle after the header
    always_ff @(posedge clk_in) begin
        if (reset_in || soft_rst) begin
            drop_valid_out <= 1'b0;
            drop_out <= 1'b0;
            storm_count_out <= 1'b0;
        end else begin
            drop_valid_out <= frame_valid_in;
            drop_out <= frame_valid_in && (
                (ctrl_a_r[sgc_pkg::SGC_A_STRICT_CTRL] ?
                    (frame_in.type_len == sgc_pkg::SGC_PAUSE_TYPE ||
                     frame_in.dest == sgc_pkg::SGC_PAUSE_DA) :
                    frame_in.is_flow_ctrl) || // RQ6
                (ctrl_b_r[sgc_pkg::SGC_B_LEN_CHECK] &&
                 frame_in.type_len < sgc_pkg::SGC_LEN_LIMIT &&
                 frame_in.type_len != frame_in.payload_len) || // RQ13
                (frame_in.crosses_vlan &&
                 !vlan_r[sgc_pkg::SGC_V_VLAN_CROSS] &&
                 (!frame_in.known_ucast ||
                  (frame_in.single_dest && frame_in.mirrored_away)))); // RQ18
            storm_count_out <= frame_valid_in &&
                (frame_in.dest == sgc_pkg::SGC_BCAST_DA ||
                 (frame_in.is_mcast &&
                  !vlan_r[sgc_pkg::SGC_V_STORM_BCAST])); // RQ19
        end
    end

    // link pins are asynchronous; loss is seen on the second stage only
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            link_s1_r <= '0;
            link_s2_r <= '0;
            link_prev_r <= '0;
        end else begin
            link_s1_r <= link_up_in;
            link_s2_r <= link_s1_r;
            link_prev_r <= link_s2_r;
        end
    end

    assign age_period = (ctrl_b_r[sgc_pkg::SGC_B_FAST_AGE] || fast_once_r) ?
        sgc_pkg::SGC_AGE_W'(FAST_AGE_CYC) :
        sgc_pkg::SGC_AGE_W'(NORMAL_AGE_CYC); // RQ15
    assign age_end = age_cnt_r >= age_period - 1'b1;

    // aging timer; a link loss restarts it on one short cycle
    always_ff @(posedge clk_in) begin
        if (reset_in || soft_rst) begin
            age_cnt_r <= '0;
            fast_once_r <= 1'b0;
            age_tick_out <= 1'b0;
        end else if (!ctrl_b_r[sgc_pkg::SGC_B_AGING]) begin
            age_cnt_r <= '0; // RQ14
            fast_once_r <= 1'b0;
            age_tick_out <= 1'b0;
        end else if (link_loss && ctrl_a_r[sgc_pkg::SGC_A_LINK_AGE]) begin
            age_cnt_r <= '0;
            fast_once_r <= 1'b1; // RQ7
            age_tick_out <= 1'b0;
        end else if (age_end) begin
            age_cnt_r <= '0;
            fast_once_r <= 1'b0; // RQ7
            age_tick_out <= 1'b1;
        end else begin
            age_cnt_r <= age_cnt_r + 1'b1;
            age_tick_out <= 1'b0;
        end
    end

    // registered outputs from configuration, plus the link loss age-out pulse
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            core_reset_out <= 1'b1;
            rx_enable_out <= 1'b0;
            conf_backoff_out <= 1'b0;
            aggr_backoff_out <= 1'b0;
            jumbo_en_out <= 1'b0;
            tx_fc_en_out <= 1'b0;
            rx_fc_en_out <= 1'b0;
            age_all_out <= 1'b0;
        end else begin
            core_reset_out <= soft_rst; // RQ2
            rx_enable_out <= !soft_rst; // RQ2
            conf_backoff_out <= ctrl_a_r[sgc_pkg::SGC_A_CONF_BACKOFF]; // RQ1
            aggr_backoff_out <= ctrl_b_r[sgc_pkg::SGC_B_AGGR_BACKOFF]; // RQ16
            jumbo_en_out <= ctrl_b_r[sgc_pkg::SGC_B_JUMBO]; // RQ9
            tx_fc_en_out <= an_tx_pause_in &&
                !ctrl_b_r[sgc_pkg::SGC_B_TX_FC_DIS]; // RQ10
            rx_fc_en_out <= an_rx_pause_in &&
                !ctrl_b_r[sgc_pkg::SGC_B_RX_FC_DIS]; // RQ11
            age_all_out <= link_loss && !soft_rst; // RQ8
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;

    // checks
    wb_ack_pulse_a: assert property (@(posedge clk_in) disable iff (reset_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    soft_rst_rx_a: assert property (@(posedge clk_in) disable iff (reset_in)
        soft_rst |=> !rx_enable_out && core_reset_out) // RQ2
        else $error("reception not stopped under soft reset");
    dyn_flush_start_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        wr_req && idx == sgc_pkg::SGC_IDX_CTRL_A && wbyte[5] && !soft_rst &&
        flush_r == sgc_pkg::SGC_FL_IDLE && !wbyte[6] && !ctrl_a_r[4]
        |=> ##1 flush_dyn_start_out) // RQ3
        else $error("dynamic flush not started");
    flush_busy_a: assert property (@(posedge clk_in) disable iff (reset_in)
        flush_r == sgc_pkg::SGC_FL_DYN && !flush_done_in && !soft_rst
        |-> ctrl_a_r[sgc_pkg::SGC_A_FLUSH_DYN]) // RQ20
        else $error("flush bit cleared while busy");
    strict_drop_a: assert property (@(posedge clk_in) disable iff (reset_in)
        frame_valid_in && !soft_rst && ctrl_a_r[1] &&
        frame_in.type_len == 16'h8808 |=> drop_out) // RQ6
        else $error("pause type frame not dropped");
    len_drop_a: assert property (@(posedge clk_in) disable iff (reset_in)
        frame_valid_in && !soft_rst && ctrl_b_r[3] &&
        frame_in.type_len < sgc_pkg::SGC_LEN_LIMIT &&
        frame_in.type_len != frame_in.payload_len |=> drop_out) // RQ13
        else $error("length mismatch frame not dropped");
    storm_bcast_a: assert property (@(posedge clk_in) disable iff (reset_in)
        frame_valid_in && !soft_rst && vlan_r[6] &&
        frame_in.dest != 48'hffffffffffff |=> !storm_count_out) // RQ19
        else $error("non broadcast counted for storm");
    aging_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !ctrl_b_r[2] [*2] |=> !age_tick_out) // RQ14
        else $error("aging tick while aging disabled");
    link_age_all_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(link_s2_r[0]) && !soft_rst |=> age_all_out) // RQ8
        else $error("link loss did not age out addresses");
    tx_fc_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ctrl_b_r[5] [*2] |=> !tx_fc_en_out) // RQ10
        else $error("transmit pause on while disabled");
    stat_qual_a: assert property (@(posedge clk_in) disable iff (reset_in)
        entry_valid_in && entry_in.is_static && !entry_in.unicast &&
        !soft_rst |=> !entry_remove_out) // RQ5
        else $error("multicast entry removed");
endmodule : sgc_switch_global_control_regs

// File: sim/sgc_switch_global_control_regs_tb.sv
// sgc_switch_global_control_regs_tb: self-checking bench for the global
// control register bank, driving wishbone, frame and table-entry ports.
// assumes short aging counts (20 and 50 cycles) set at instantiation.
`timescale 1ns/1ps
module sgc_switch_global_control_regs_tb;
    localparam longint FAST = 20;
    localparam longint SLOW = 50;
    logic clk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0, strap = 1;
    logic antx = 0, anrx = 0, fv = 0, ev = 0, fd = 0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [4:0] link = 5'h1f, ld = 5'h00;
    sgc_pkg::sgc_frame_t fr = '0;
    sgc_pkg::sgc_entry_t en = '0;
    logic core_rst, rx_en, conf_bo, aggr_bo, jumbo, tx_fc, rx_fc, dyn_st;
    logic stat_st, rm, dv, drop, storm, tick, age_all;
    int err_count = 0, checked = 0, dyn_n = 0, stat_n = 0;

    // clock and pulse counters; counting avoids racing one-cycle pulses
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (dyn_st === 1'b1) dyn_n++;
        if (stat_st === 1'b1) stat_n++;
    end

    sgc_switch_global_control_regs #(.FAST_AGE_CYC(FAST),
        .NORMAL_AGE_CYC(SLOW)) dut (.clk_in(clk_in), .reset_in(reset_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .strap_fc_dis_in(strap), .link_up_in(link),
        .an_tx_pause_in(antx), .an_rx_pause_in(anrx), .frame_valid_in(fv),
        .frame_in(fr), .entry_valid_in(ev), .entry_in(en),
        .learn_dis_in(ld), .flush_done_in(fd), .core_reset_out(core_rst),
        .rx_enable_out(rx_en), .conf_backoff_out(conf_bo),
        .aggr_backoff_out(aggr_bo), .jumbo_en_out(jumbo),
        .tx_fc_en_out(tx_fc), .rx_fc_en_out(rx_fc),
        .flush_dyn_start_out(dyn_st), .flush_stat_start_out(stat_st),
        .entry_remove_out(rm), .drop_valid_out(dv), .drop_out(drop),
        .storm_count_out(storm), .age_tick_out(tick),
        .age_all_out(age_all));

    task conclude;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [7:0] q);
        int n;
        @(posedge clk_in);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 0; stb <= 0;
        if (n >= 20) begin
            err_count++;
            conclude();
        end
    endtask : bus

    // cycles between two aging ticks, the first tick only aligns
    task gap(output int n);
        n = 0;
        while (tick !== 1'b1 && n < 200) begin @(posedge clk_in); n++; end
        n = 0;
        do begin @(posedge clk_in); n++; end while (tick !== 1'b1 && n < 200);
    endtask : gap

    function logic exp_drop(sgc_pkg::sgc_frame_t f, logic [3:0] c);
        logic d;
        d = c[0] ? (f.type_len == sgc_pkg::SGC_PAUSE_TYPE ||
                    f.dest == sgc_pkg::SGC_PAUSE_DA) : f.is_flow_ctrl;
        d |= c[1] && f.type_len < sgc_pkg::SGC_LEN_LIMIT &&
             f.type_len != f.payload_len;
        d |= f.crosses_vlan && !c[2] &&
             (!f.known_ucast || (f.single_dest && f.mirrored_away));
        return d;
    endfunction : exp_drop

    function logic exp_rm(logic st, sgc_pkg::sgc_entry_t e, logic [4:0] l);
        if (st) return e.is_static && e.unicast && $onehot(e.fwd_ports) &&
                       (e.fwd_ports & l) != 5'h00;
        return !e.is_static && l[e.port];
    endfunction : exp_rm

    // main sequence: reset values, register fields, flushes, frames, aging
    initial begin
        logic [7:0] q, d, e;
        logic [95:0] t;
        logic [7:0] rst_exp [4];
        int n, k;
        sgc_pkg::sgc_entry_t x;
        sgc_pkg::sgc_frame_t y;
        rst_exp = '{8'h0c, 8'h34, 8'hc0, 8'h00};
        n = $urandom(32);
        repeat (4) @(posedge clk_in);
        reset_in <= 0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(8 + 4 * i), 8'h00, q);
            chk(q, rst_exp[i]);
        end
        bus(1'b1, 8'h14, 8'hff, q);
        bus(1'b0, 8'h14, 8'h00, q);
        chk(q, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom()) & 8'hcf;
            e = 8'($urandom());
            antx <= 1'($urandom()); anrx <= 1'($urandom());
            bus(1'b1, 8'h08, d, q);
            bus(1'b1, 8'h0c, e, q);
            bus(1'b1, 8'h10, ~e, q);
            bus(1'b0, 8'h08, 8'h00, q);
            chk(q, (d & 8'hc3) | 8'h0c);
            chk({conf_bo, core_rst, rx_en}, {d[7], d[6], !d[6]});
            bus(1'b0, 8'h0c, 8'h00, q);
            chk(q, e & 8'h7f);
            chk({jumbo, aggr_bo}, {e[6], e[0]});
            chk({tx_fc, rx_fc}, {antx & !e[5], anrx & !e[4]});
            bus(1'b0, 8'h10, 8'h00, q);
            chk(q, ~e & 8'hc0);
        end
        // soft reset blocks frames but keeps configuration
        bus(1'b1, 8'h0c, 8'h5a, q);
        bus(1'b1, 8'h08, 8'h40, q);
        @(posedge clk_in); fv <= 1; fr.type_len <= sgc_pkg::SGC_PAUSE_TYPE;
        @(posedge clk_in); fv <= 0;
        @(posedge clk_in); chk(dv, 1'b0);
        bus(1'b0, 8'h0c, 8'h00, q);
        chk(q, 8'h5a);
        bus(1'b1, 8'h08, 8'h00, q);
        for (int m = 0; m < 2; m++) begin
            k = m ? stat_n : dyn_n;
            bus(1'b1, 8'h08, m ? 8'h10 : 8'h20, q);
            bus(1'b1, 8'h08, 8'h00, q);
            chk(m ? stat_n - k : dyn_n - k, 1);
            bus(1'b0, 8'h08, 8'h00, q);
            chk(q, m ? 8'h1c : 8'h2c);
            for (int i = 0; i < 12; i++) begin
                t = {$urandom(), $urandom(), $urandom()};
                x = t[9:0];
                x.port = 3'($urandom() % 5);
                if (t[40]) x.fwd_ports = 5'(1 << x.port);
                @(posedge clk_in); ev <= 1; ld <= t[36:32]; en <= x;
                @(posedge clk_in); ev <= 0;
                @(posedge clk_in);
                chk(rm, exp_rm(m[0], x, t[36:32]));
            end
            @(posedge clk_in); fd <= 1;
            @(posedge clk_in); fd <= 0;
            bus(1'b0, 8'h08, 8'h00, q);
            chk(q, 8'h0c);
        end
        // every filter configuration, corner frames mixed with random ones
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, 8'h08, {6'h0, c[0], 1'b0}, q);
            bus(1'b1, 8'h0c, {4'h0, c[1], 3'h0}, q);
            bus(1'b1, 8'h10, {c[2], c[3], 6'h0}, q);
            for (int i = 0; i < 6; i++) begin
                t = {$urandom(), $urandom(), $urandom()};
                y = t[85:0];
                case (i % 4)
                    0: y.type_len = sgc_pkg::SGC_PAUSE_TYPE;
                    1: y.dest = sgc_pkg::SGC_PAUSE_DA;
                    2: y.dest = sgc_pkg::SGC_BCAST_DA;
                    default: y.type_len = 16'(t[90:80] % sgc_pkg::SGC_LEN_LIMIT);
                endcase
                if (t[95]) y.payload_len = y.type_len;
                @(posedge clk_in); fv <= 1; fr <= y;
                @(posedge clk_in); fv <= 0;
                @(posedge clk_in);
                chk({dv, drop}, {1'b1, exp_drop(fr, c[3:0])});
                chk(storm, fr.dest == sgc_pkg::SGC_BCAST_DA ||
                    (!c[3] && fr.is_mcast));
            end
        end
        bus(1'b1, 8'h0c, 8'h06, q);
        gap(n); gap(n);
        chk(n, FAST);
        bus(1'b1, 8'h0c, 8'h04, q);
        gap(n); gap(n);
        chk(n, SLOW);
        bus(1'b1, 8'h0c, 8'h00, q);
        k = 0;
        repeat (120) begin @(posedge clk_in); if (tick === 1'b1) k++; end
        chk(k, 0);
        // second reset with the strap low, then one fast cycle on link loss
        strap <= 0; reset_in <= 1;
        repeat (4) @(posedge clk_in);
        reset_in <= 0;
        bus(1'b0, 8'h0c, 8'h00, q);
        chk(q, 8'h04);
        bus(1'b1, 8'h08, 8'h01, q);
        @(posedge clk_in); link[0] <= 1'b0;
        n = 0;
        while (age_all !== 1'b1 && n < 10) begin @(posedge clk_in); n++; end
        chk(age_all, 1'b1);
        n = 0;
        do begin @(posedge clk_in); n++; end while (tick !== 1'b1 && n < 200);
        chk(n, FAST);
        n = 0;
        do begin @(posedge clk_in); n++; end while (tick !== 1'b1 && n < 200);
        chk(n, SLOW);
        conclude();
    end
endmodule : sgc_switch_global_control_regs_tb
